// ### src/adcsw_pkg.sv
// Behaviour
// - shadow channel/reference copied while idle
// - selections frozen once conversion starts
// - copying resumes in final conversion cycle
// - start on next conversion-clock edge
// - over-reference input saturates to full scale
// - reference code zero means internal reference
// - result register valid when ready flag set
// - temperature channel switches sensor on
// - four window conditions set match flag
// - compare mode zero disables window compare
// - compare once after last accumulated sample
// - event trigger enable starts on events
// - ready vector first, window vector second
// - each flag set on event, own enable
// - request held while enable and flag set
// - standby halts unless run-while-sleeping set
// - standby starts only from events; clock request
// - event edge sets start bit, completion clears
// - initial delay before first standby conversion
// - power-down pauses; result flagged, contents invalid (halted_reg records the cut but drives no flag or output)
// - ready flag cleared by result read or write-one
// - plain conversion lasts thirteen clock cycles
package adcsw_pkg;
	// register indices; byte address is four times the index
	localparam logic [4:0] IDX_CTRLA    = 5'h00;
	localparam logic [4:0] IDX_CTRLB    = 5'h01;
	localparam logic [4:0] IDX_CTRLC    = 5'h02;
	localparam logic [4:0] IDX_CTRLD    = 5'h03;
	localparam logic [4:0] IDX_CTRLE    = 5'h04;
	localparam logic [4:0] IDX_SAMPCTRL = 5'h05;
	localparam logic [4:0] IDX_MUX      = 5'h06;
	localparam logic [4:0] IDX_COMMAND  = 5'h08;
	localparam logic [4:0] IDX_EVCTRL   = 5'h09;
	localparam logic [4:0] IDX_INTEN    = 5'h0a;
	localparam logic [4:0] IDX_INTFLAG  = 5'h0b;
	localparam logic [4:0] IDX_RESULT   = 5'h10;
	localparam logic [4:0] IDX_WINLOW   = 5'h12;
	localparam logic [4:0] IDX_WINHIGH  = 5'h14;
	localparam int         ADDR_W       = 7;
	// writable bit masks
	localparam logic [7:0] CTRLA_MASK   = 8'h85;
	localparam logic [7:0] CTRLB_MASK   = 8'h07;
	localparam logic [7:0] CTRLC_MASK   = 8'h77;
	localparam logic [7:0] CTRLD_MASK   = 8'hef;
	localparam logic [7:0] CTRLE_MASK   = 8'h07;
	localparam logic [7:0] SAMP_MASK    = 8'h1f;
	localparam logic [7:0] MUX_MASK     = 8'h1f;
	localparam logic [7:0] REG_RESET    = 8'h00;
	// field positions
	localparam int ENABLE_BIT  = 0;
	localparam int RESSEL_BIT  = 2;
	localparam int RUNSLP_BIT  = 7;
	localparam int SCAP_BIT    = 6;
	localparam int REF_LSB     = 4;
	localparam int INITD_LSB   = 5;
	localparam int FLAG_READY  = 0;
	localparam int FLAG_WIN    = 1;
	// reference and scale
	localparam logic [1:0] REF_INTERNAL = 2'h0;
	localparam logic [9:0] FULL_SCALE   = 10'h3ff;
	localparam logic [4:0] TEMP_CHANNEL = 5'h1e;
	// compare modes
	localparam logic [2:0] WCM_OFF     = 3'h0;
	localparam logic [2:0] WCM_BELOW   = 3'h1;
	localparam logic [2:0] WCM_ABOVE   = 3'h2;
	localparam logic [2:0] WCM_INSIDE  = 3'h3;
	localparam logic [2:0] WCM_OUTSIDE = 3'h4;
	// timing in conversion-clock cycles
	localparam logic [8:0] CONV_CYCLES = 9'h00d;
	localparam logic [8:0] SH_CYCLE    = 9'h002;
	localparam logic [8:0] INIT_UNIT   = 9'h010;
	localparam logic [2:0] ACC_MAX     = 3'h6;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_CONV = 3'b100
	} adcsw_state_t;
endpackage

// ### src/adcsw_top.sv
`timescale 1ns/1ps
`default_nettype none
module adcsw_top (
	// apb slave
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic [adcsw_pkg::ADDR_W-1:0] paddr,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// events and sleep
	input  wire logic                         event_in,
	input  wire logic                         standby_sleep,
	input  wire logic                         powerdown_sleep,
	// converter core
	input  wire logic [9:0]                   conv_code,
	input  wire logic                         conv_over_ref,
	output logic      [4:0]                   applied_channel,
	output logic      [1:0]                   applied_reference,
	output logic                              applied_sample_cap,
	output logic                              temp_sensor_on,
	output logic                              sample_hold,
	output logic                              clock_request,
	// interrupt requests
	output logic                              irq_result,
	output logic                              irq_window
);
	import adcsw_pkg::*;

	logic [7:0]   ctrla_reg;
	logic [7:0]   ctrlb_reg;
	logic [7:0]   ctrlc_reg;
	logic [7:0]   ctrld_reg;
	logic [7:0]   ctrle_reg;
	logic [7:0]   sampctrl_reg;
	logic [7:0]   mux_reg;
	logic         evctrl_reg;
	logic [1:0]   inten_reg;
	logic [1:0]   intflag_reg;
	logic         start_reg;
	logic [15:0]  result_reg;
	logic [15:0]  winlow_reg;
	logic [15:0]  winhigh_reg;
	logic [15:0]  acc_reg;
	logic [7:0]   presc_reg;
	logic [8:0]   cycle_reg;
	logic [8:0]   last_reg;
	logic [6:0]   samples_reg;
	logic         lock_reg;
	logic         event_prev_reg;
	logic         standby_prev_reg;
	logic         init_pend_reg;
	logic         halted_reg;
	adcsw_state_t state_reg;

	// bus decode
	logic       access;
	logic       wr;
	logic       rd;
	logic [4:0] idx;
	logic       mapped;
	assign idx    = paddr[ADDR_W-1:2];
	assign access = psel & penable & pready;
	assign wr     = access & pwrite;
	assign rd     = access & ~pwrite;

	function automatic logic is_mapped(input logic [4:0] i);
		case (i)
			IDX_CTRLA, IDX_CTRLB, IDX_CTRLC, IDX_CTRLD, IDX_CTRLE,
			IDX_SAMPCTRL, IDX_MUX, IDX_COMMAND, IDX_EVCTRL, IDX_INTEN,
			IDX_INTFLAG, IDX_RESULT, IDX_WINLOW, IDX_WINHIGH: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction
	assign mapped = is_mapped(idx) & (paddr[1:0] == 2'h0);

	function automatic logic wr_to(input logic [4:0] i);
		wr_to = wr & mapped & (idx == i);
	endfunction

	// strict window test
	function automatic logic win_hit(input logic [2:0] m, input logic [15:0] r,
		input logic [15:0] lo, input logic [15:0] hi);
		case (m)
			WCM_BELOW:   win_hit = r < lo;
			WCM_ABOVE:   win_hit = r > hi;
			WCM_INSIDE:  win_hit = (r > lo) && (r < hi);
			WCM_OUTSIDE: win_hit = (r < lo) || (r > hi);
			default:     win_hit = 1'b0;
		endcase
	endfunction

	// read mux
	logic [31:0] rd_value;
	always_comb
	begin
		case (idx)
			IDX_CTRLA:    rd_value = {24'h0, ctrla_reg};
			IDX_CTRLB:    rd_value = {24'h0, ctrlb_reg};
			IDX_CTRLC:    rd_value = {24'h0, ctrlc_reg};
			IDX_CTRLD:    rd_value = {24'h0, ctrld_reg};
			IDX_CTRLE:    rd_value = {24'h0, ctrle_reg};
			IDX_SAMPCTRL: rd_value = {24'h0, sampctrl_reg};
			IDX_MUX:      rd_value = {24'h0, mux_reg};
			IDX_COMMAND:  rd_value = {31'h0, start_reg};
			IDX_EVCTRL:   rd_value = {31'h0, evctrl_reg};
			IDX_INTEN:    rd_value = {30'h0, inten_reg};
			IDX_INTFLAG:  rd_value = {30'h0, intflag_reg};
			IDX_RESULT:   rd_value = {16'h0, result_reg};
			IDX_WINLOW:   rd_value = {16'h0, winlow_reg};
			IDX_WINHIGH:  rd_value = {16'h0, winhigh_reg};
			default:      rd_value = 32'h0;
		endcase
	end

	// no wait state; pready and read data still leave a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= (psel & ~penable & mapped) ? rd_value : 32'h0;
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrla_reg    <= REG_RESET;
			ctrlb_reg    <= REG_RESET;
			ctrlc_reg    <= REG_RESET;
			ctrld_reg    <= REG_RESET;
			ctrle_reg    <= REG_RESET;
			sampctrl_reg <= REG_RESET;
			mux_reg      <= REG_RESET;
			evctrl_reg   <= 1'b0;
			inten_reg    <= 2'h0;
			winlow_reg   <= 16'h0;
			winhigh_reg  <= 16'h0;
		end
		else
		begin
			if (wr_to(IDX_CTRLA))
				ctrla_reg <= pwdata[7:0] & CTRLA_MASK;
			if (wr_to(IDX_CTRLB))
				ctrlb_reg <= pwdata[7:0] & CTRLB_MASK;
			if (wr_to(IDX_CTRLC))
				ctrlc_reg <= pwdata[7:0] & CTRLC_MASK;
			if (wr_to(IDX_CTRLD))
				ctrld_reg <= pwdata[7:0] & CTRLD_MASK;
			if (wr_to(IDX_CTRLE))
				ctrle_reg <= pwdata[7:0] & CTRLE_MASK;
			if (wr_to(IDX_SAMPCTRL))
				sampctrl_reg <= pwdata[7:0] & SAMP_MASK;
			// shadow only; the applied copy lives below
			if (wr_to(IDX_MUX))
				mux_reg <= pwdata[7:0] & MUX_MASK;
			if (wr_to(IDX_EVCTRL))
				evctrl_reg <= pwdata[0];
			if (wr_to(IDX_INTEN))
				inten_reg <= pwdata[1:0];
			if (wr_to(IDX_WINLOW))
				winlow_reg <= pwdata[15:0];
			if (wr_to(IDX_WINHIGH))
				winhigh_reg <= pwdata[15:0];
		end
	end

	// sleep gating and triggers
	logic active;
	logic runnable;
	logic ev_rise;
	logic sw_start;
	logic trigger;
	logic tick;
	logic [7:0] presc_last;
	assign runnable   = ctrla_reg[ENABLE_BIT] & (~standby_sleep | ctrla_reg[RUNSLP_BIT]);
	assign active     = runnable & ~powerdown_sleep;
	assign ev_rise    = event_in & ~event_prev_reg;
	// software start is ignored in standby; only events run there
	assign sw_start   = wr_to(IDX_COMMAND) & pwdata[0] & ~standby_sleep;
	assign trigger    = (sw_start | (ev_rise & evctrl_reg)) & active;
	assign presc_last = 8'((16'h2 << ctrlc_reg[2:0]) - 16'h1);
	assign tick       = active & (state_reg != ST_IDLE) & (presc_reg == presc_last);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			event_prev_reg   <= 1'b0;
			standby_prev_reg <= 1'b0;
		end
		else
		begin
			event_prev_reg   <= event_in;
			standby_prev_reg <= standby_sleep;
		end
	end

	// prescaler held at zero while idle gives a fixed start delay
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			presc_reg <= 8'h0;
		else if (state_reg == ST_IDLE || !ctrla_reg[ENABLE_BIT] || tick)
			presc_reg <= 8'h0;
		else if (active)
			presc_reg <= presc_reg + 8'h1;
	end

	// sample geometry
	logic [8:0] base_last;
	logic [8:0] init_extra;
	logic [6:0] acc_total;
	logic       last_cycle;
	logic       final_sample;
	logic [9:0] raw_code;
	logic [15:0] sample_val;
	logic [15:0] acc_sum;
	assign base_last  = CONV_CYCLES - 9'h1 + {5'h0, ctrld_reg[3:0]} + {4'h0, sampctrl_reg[4:0]};
	assign init_extra = 9'(ctrld_reg[7:INITD_LSB] * INIT_UNIT);
	assign acc_total  = (ctrlb_reg[2:0] > ACC_MAX) ? 7'h1 : 7'(8'h1 << ctrlb_reg[2:0]);
	assign last_cycle = tick & (state_reg == ST_CONV) & (cycle_reg == last_reg);
	assign final_sample = (samples_reg == acc_total - 7'h1);
	assign raw_code   = conv_over_ref ? FULL_SCALE : conv_code;
	assign sample_val = ctrla_reg[RESSEL_BIT] ? {8'h0, raw_code[9:2]} : {6'h0, raw_code};
	assign acc_sum    = acc_reg + sample_val;

	// standby entry arms the settling delay for the next start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			init_pend_reg <= 1'b0;
		else if (standby_sleep & ~standby_prev_reg)
			init_pend_reg <= 1'b1;
		else if (state_reg == ST_WAIT && tick)
			init_pend_reg <= 1'b0;
	end

	// sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg   <= ST_IDLE;
			cycle_reg   <= 9'h0;
			last_reg    <= 9'h0;
			samples_reg <= 7'h0;
			acc_reg     <= 16'h0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (trigger)
						state_reg <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (!ctrla_reg[ENABLE_BIT])
						state_reg <= ST_IDLE;
					else if (tick)
					begin
						state_reg   <= ST_CONV;
						cycle_reg   <= 9'h0;
						samples_reg <= 7'h0;
						acc_reg     <= 16'h0;
						last_reg    <= base_last + (init_pend_reg ? init_extra : 9'h0);
					end
				end
				ST_CONV:
				begin
					if (!ctrla_reg[ENABLE_BIT])
						state_reg <= ST_IDLE;
					else if (last_cycle)
					begin
						acc_reg     <= acc_sum;
						cycle_reg   <= 9'h0;
						last_reg    <= base_last;
						samples_reg <= samples_reg + 7'h1;
						if (final_sample)
							state_reg <= ST_IDLE;
					end
					else if (tick)
						cycle_reg <= cycle_reg + 9'h1;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// start bit tracks the busy interval
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			start_reg <= 1'b0;
		else if (trigger && state_reg == ST_IDLE)
			start_reg <= 1'b1;
		else if ((last_cycle && final_sample) || !ctrla_reg[ENABLE_BIT])
			start_reg <= 1'b0;
	end

	// remembers that power-down cut into this conversion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			halted_reg <= 1'b0;
		else if (state_reg == ST_IDLE)
			halted_reg <= 1'b0;
		else if (powerdown_sleep)
			halted_reg <= 1'b1;
	end

	// result and compare once per conversion
	logic done;
	assign done = last_cycle & final_sample;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			result_reg <= 16'h0;
		else if (done)
			result_reg <= acc_sum;
	end

	// flags: hardware set beats a same-cycle clear
	logic win_set;
	logic rdy_clr;
	logic win_clr;
	assign win_set = done & (ctrle_reg[2:0] != WCM_OFF)
		& win_hit(ctrle_reg[2:0], acc_sum, winlow_reg, winhigh_reg);
	assign rdy_clr = (rd & mapped & (idx == IDX_RESULT))
		| (wr_to(IDX_INTFLAG) & pwdata[FLAG_READY]);
	assign win_clr = wr_to(IDX_INTFLAG) & pwdata[FLAG_WIN];
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			intflag_reg <= 2'h0;
		else
		begin
			if (done)
				intflag_reg[FLAG_READY] <= 1'b1;
			else if (rdy_clr)
				intflag_reg[FLAG_READY] <= 1'b0;
			if (win_set)
				intflag_reg[FLAG_WIN] <= 1'b1;
			else if (win_clr)
				intflag_reg[FLAG_WIN] <= 1'b0;
		end
	end

	// request lines, ready first in vector order
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_result <= 1'b0;
			irq_window <= 1'b0;
		end
		else
		begin
			irq_result <= inten_reg[FLAG_READY] & intflag_reg[FLAG_READY];
			irq_window <= inten_reg[FLAG_WIN] & intflag_reg[FLAG_WIN];
		end
	end

	// lock selections across the conversion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lock_reg <= 1'b0;
		else if (state_reg == ST_WAIT && tick)
			lock_reg <= 1'b1;
		else if (tick && state_reg == ST_CONV && final_sample
			&& cycle_reg == last_reg - 9'h1)
			lock_reg <= 1'b0;
		else if (state_reg == ST_IDLE)
			lock_reg <= 1'b0;
	end

	// applied copies follow the shadow whenever unlocked, except in the wait-state tick cycle that sets the lock
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			applied_channel    <= 5'h0;
			applied_reference  <= REF_INTERNAL;
			applied_sample_cap <= 1'b0;
			temp_sensor_on     <= 1'b0;
		end
		else
		begin
			if (!lock_reg && !(state_reg == ST_WAIT && tick))
			begin
				applied_channel    <= mux_reg[4:0];
				applied_reference  <= ctrlc_reg[REF_LSB+1:REF_LSB];
				applied_sample_cap <= ctrlc_reg[SCAP_BIT];
			end
			temp_sensor_on <= (applied_channel == TEMP_CHANNEL);
		end
	end

	// sample strobe and clock request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sample_hold   <= 1'b0;
			clock_request <= 1'b0;
		end
		else
		begin
			sample_hold   <= tick & (state_reg == ST_CONV)
				& (cycle_reg == SH_CYCLE + {5'h0, ctrld_reg[3:0]});
			// released as soon as the sequencer goes idle
			clock_request <= (state_reg != ST_IDLE) & ~done;
		end
	end

	logic unused_ok;
	assign unused_ok = &{1'b0, pwdata[31:16], halted_reg};
endmodule
`default_nettype wire

// ### tb/adcsw_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adcsw_chk (
	// apb
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic [adcsw_pkg::ADDR_W-1:0] paddr,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic [31:0]                  prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	// converter side
	input wire logic [4:0]                   applied_channel,
	input wire logic                         temp_sensor_on,
	input wire logic                         sample_hold,
	input wire logic                         clock_request,
	input wire logic                         irq_result,
	input wire logic                         irq_window
);
	import adcsw_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_PRDATA_QUIET: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside access");
	AST_MISALIGN_ERR: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access without error");
	AST_CTRLA_OK: assert property (pready && paddr == {IDX_CTRLA, 2'h0} |-> !pslverr)
		else $error("error on mapped register");
	AST_TEMP_ON: assert property (temp_sensor_on == ($past(applied_channel) == TEMP_CHANNEL))
		else $error("temperature sensor enable wrong");
	AST_HOLD_BUSY: assert property (sample_hold |-> clock_request)
		else $error("sample taken without clock request");
	AST_IRQR_HOLD: assert property (irq_result && !pready && !$past(pready) |=> irq_result)
		else $error("result request dropped without cause");
	AST_IRQW_HOLD: assert property (irq_window && !pready && !$past(pready) |=> irq_window)
		else $error("window request dropped without cause");
	AST_IRQ_CAUSE: assert property ($rose(irq_result)
		|-> (!$past(clock_request) && $past(clock_request, 2)) || $past(pready, 2))
		else $error("result request rose without cause");
endmodule
bind adcsw_top adcsw_chk adcsw_chk_i (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .applied_channel(applied_channel),
	.temp_sensor_on(temp_sensor_on), .sample_hold(sample_hold), .clock_request(clock_request),
	.irq_result(irq_result), .irq_window(irq_window)
);
`default_nettype wire

// ### tb/tb_adcsw_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adcsw_top;
	import adcsw_pkg::*;
	typedef struct {logic [2:0] m; logic [9:0] lo; logic [9:0] hi; logic [9:0] c; logic w;} adcsw_row_t;
	logic              pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata, rd;
	logic              pready, pslverr, er, event_in = 1'h0, standby_sleep = 1'h0, powerdown_sleep = 1'h0;
	logic [9:0]        conv_code = '0;
	logic              conv_over_ref = 1'h0, applied_sample_cap, temp_sensor_on, sample_hold;
	logic              clock_request, irq_result, irq_window;
	logic [4:0]        applied_channel;
	logic [1:0]        applied_reference;
	int                err_total = 0, checked = 0, cyc = 0, busy = 0, holds = 0;
	logic [4:0]        ridx [6] = '{IDX_CTRLA, IDX_CTRLC, IDX_MUX, IDX_INTFLAG, IDX_RESULT, IDX_CTRLE};
	adcsw_row_t        rows [10] = '{
		'{WCM_OFF, 10'h000, 10'h3ff, 10'h100, 1'h0}, '{WCM_BELOW, 10'h100, 10'h3ff, 10'h0ff, 1'h1},
		'{WCM_BELOW, 10'h100, 10'h3ff, 10'h100, 1'h0}, '{WCM_ABOVE, 10'h000, 10'h200, 10'h201, 1'h1},
		'{WCM_ABOVE, 10'h000, 10'h200, 10'h200, 1'h0}, '{WCM_INSIDE, 10'h100, 10'h200, 10'h150, 1'h1},
		'{WCM_INSIDE, 10'h100, 10'h200, 10'h200, 1'h0}, '{WCM_OUTSIDE, 10'h100, 10'h200, 10'h050, 1'h1},
		'{WCM_OUTSIDE, 10'h100, 10'h200, 10'h150, 1'h0}, '{3'h7, 10'h000, 10'h3ff, 10'h100, 1'h0}};
	always #25 pclk = ~pclk;
	adcsw_top adcsw_top_i (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
		.standby_sleep(standby_sleep), .powerdown_sleep(powerdown_sleep), .conv_code(conv_code),
		.conv_over_ref(conv_over_ref), .applied_channel(applied_channel), .applied_reference(applied_reference),
		.applied_sample_cap(applied_sample_cap), .temp_sensor_on(temp_sensor_on), .sample_hold(sample_hold),
		.clock_request(clock_request), .irq_result(irq_result), .irq_window(irq_window)
	);
	task automatic close_out();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wreg(input logic [4:0] x, input logic [31:0] d);
		apb(1'h1, {x, 2'h0}, d);
	endtask
	task automatic rreg(input logic [4:0] x);
		apb(1'h0, {x, 2'h0}, 32'h0);
	endtask
	// polls the start bit, which reads as busy
	task automatic wait_done();
		do rreg(IDX_COMMAND); while (rd[0] !== 1'h0);
	endtask
	task automatic conv(input logic [9:0] c);
		conv_code <= c;
		wreg(IDX_COMMAND, 32'h1);
		wait_done();
	endtask
	task automatic evt();
		@(posedge pclk);
		event_in <= 1'h1;
		repeat (2) @(posedge pclk);
		event_in <= 1'h0;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		busy += int'(clock_request === 1'h1);
		holds += int'(sample_hold === 1'h1);
		if (cyc == 30000)
		begin
			err_total++;
			close_out();
		end
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		foreach (ridx[k])
		begin
			rreg(ridx[k]);
			chk("reset value", rd, 32'h0);
		end
		apb(1'h0, 7'h01, 32'h0);
		chk("misaligned error", 32'(er), 32'h1);
		chk("misaligned data", rd, 32'h0);
		wreg(IDX_CTRLA, 32'h1);
		apb(1'h1, 7'h01, 32'h0);
		rreg(IDX_CTRLA);
		chk("misaligned write dropped", rd, 32'h1);
		wreg(IDX_INTEN, 32'h2);
		for (int i = 0; i < 10; i++)
		begin
			wreg(IDX_CTRLE, 32'(rows[i].m));
			wreg(IDX_WINLOW, 32'(rows[i].lo));
			wreg(IDX_WINHIGH, 32'(rows[i].hi));
			conv(rows[i].c);
			chk("irq_window", 32'(irq_window), 32'(rows[i].w));
			rreg(IDX_INTFLAG);
			chk("flags", rd, {30'h0, rows[i].w, 1'h1});
			rreg(IDX_RESULT);
			chk("result", rd, 32'(rows[i].c));
			rreg(IDX_INTFLAG);
			chk("ready cleared by read", 32'(rd[0]), 32'h0);
			wreg(IDX_INTFLAG, 32'h2);
		end
		// two samples of 0x0c0 only pass the threshold once summed
		wreg(IDX_CTRLB, 32'h1);
		wreg(IDX_CTRLE, 32'(WCM_ABOVE));
		wreg(IDX_WINHIGH, 32'h100);
		conv(10'h0c0);
		rreg(IDX_INTFLAG);
		chk("accumulated flags", rd, 32'h3);
		rreg(IDX_RESULT);
		chk("accumulated result", rd, 32'h180);
		wreg(IDX_CTRLB, 32'h0);
		wreg(IDX_CTRLE, 32'h0);
		wreg(IDX_INTFLAG, 32'h3);
		wreg(IDX_CTRLA, 32'h5);
		conv(10'h2a7);
		rreg(IDX_RESULT);
		chk("eight bit result", rd, 32'h0a9);
		wreg(IDX_CTRLA, 32'h1);
		busy = 0;
		holds = 0;
		conv_over_ref <= 1'h1;
		conv(10'h123);
		conv_over_ref <= 1'h0;
		rreg(IDX_RESULT);
		chk("saturated", rd, 32'(FULL_SCALE));
		chk("conv length", 32'(busy >= 26 && busy <= 29), 32'h1);
		chk("one sample", 32'(holds), 32'h1);
		wreg(IDX_CTRLC, 32'h50);
		repeat (3) @(posedge pclk);
		chk("supply ref", {applied_sample_cap, applied_reference}, 32'h5);
		wreg(IDX_CTRLC, 32'h40);
		repeat (3) @(posedge pclk);
		chk("internal ref", 32'(applied_reference), 32'(REF_INTERNAL));
		chk("temp sample cap", 32'(applied_sample_cap), 32'h1);
		wreg(IDX_MUX, 32'(TEMP_CHANNEL));
		repeat (3) @(posedge pclk);
		chk("sensor on", 32'(temp_sensor_on), 32'h1);
		wreg(IDX_MUX, 32'h5);
		repeat (3) @(posedge pclk);
		chk("sensor off", 32'(temp_sensor_on), 32'h0);
		wreg(IDX_COMMAND, 32'h1);
		// channel change waits past one conversion clock after start
		repeat (4) @(posedge pclk);
		wreg(IDX_MUX, 32'ha);
		@(posedge pclk);
		chk("locked channel", 32'(applied_channel), 32'h5);
		wait_done();
		chk("channel follows", 32'(applied_channel), 32'ha);
		wreg(IDX_INTEN, 32'h0);
		wreg(IDX_EVCTRL, 32'h1);
		conv_code <= 10'h2a5;
		evt();
		rreg(IDX_COMMAND);
		chk("event start bit", 32'(rd[0]), 32'h1);
		wait_done();
		chk("masked irq", 32'(irq_result), 32'h0);
		rreg(IDX_INTFLAG);
		chk("ready flag", 32'(rd[0]), 32'h1);
		wreg(IDX_INTEN, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq raised", 32'(irq_result), 32'h1);
		wreg(IDX_INTFLAG, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 32'(irq_result), 32'h0);
		rreg(IDX_RESULT);
		chk("event result", rd, 32'h2a5);
		wreg(IDX_EVCTRL, 32'h0);
		evt();
		repeat (40) @(posedge pclk);
		rreg(IDX_INTFLAG);
		chk("event ignored", rd, 32'h0);
		wreg(IDX_CTRLD, 32'h20);
		wreg(IDX_CTRLA, 32'h81);
		wreg(IDX_EVCTRL, 32'h1);
		standby_sleep <= 1'h1;
		wreg(IDX_COMMAND, 32'h1);
		repeat (10) @(posedge pclk);
		rreg(IDX_COMMAND);
		chk("sw start in standby", 32'(rd[0]), 32'h0);
		for (int j = 0; j < 2; j++)
		begin
			busy = 0;
			evt();
			wait_done();
			chk("standby length", 32'(busy >= 26 + 32 * (1 - j) && busy <= 29 + 32 * (1 - j)), 32'h1);
			rreg(IDX_INTFLAG);
			chk("standby ready", 32'(rd[0]), 32'h1);
			wreg(IDX_INTFLAG, 32'h1);
		end
		wreg(IDX_CTRLA, 32'h1);
		evt();
		repeat (40) @(posedge pclk);
		rreg(IDX_INTFLAG);
		chk("standby halted", rd, 32'h0);
		chk("no clock request", 32'(clock_request), 32'h0);
		standby_sleep <= 1'h0;
		wreg(IDX_CTRLD, 32'h0);
		wreg(IDX_COMMAND, 32'h1);
		repeat (6) @(posedge pclk);
		powerdown_sleep <= 1'h1;
		repeat (100) @(posedge pclk);
		rreg(IDX_COMMAND);
		chk("paused busy", 32'(rd[0]), 32'h1);
		rreg(IDX_INTFLAG);
		chk("paused no flag", rd, 32'h0);
		powerdown_sleep <= 1'h0;
		wait_done();
		rreg(IDX_INTFLAG);
		chk("resumed flag", 32'(rd[0]), 32'h1);
		close_out();
	end
endmodule
`default_nettype wire
